//--- include/usbc_pkg.sv
// Purpose: constants for the USB descriptor and mode control block
// Assumes: 16-bit register port, word indexed
// Notes: overview below lists the behaviour the block keeps
// Overview of operation
// - Unowned descriptor is ignored by the module
// - Toggle bit picks DATA1 or DATA0
// - Toggle check on drops mismatched data packets
// - Stall bit answers STALL, descriptor untouched
// - Any STALL sets endpoint stall indication
// - Byte count rewritten with bytes moved
// - All interrupts share one request output
// - Any error flag sets error summary
// - Flags set by hardware, write one clears
// - Device mode does status phase itself
// - IN token sends buffer, sets done
// - OUT token stores data, sets done
// - Host mode uses endpoint 0 only
// - Host enable unlocks host-only control bits
// - Frame start runs from 12000, enable stops
// - SE0 to J sets attach flag
// - J indicator low means low speed
// - Bus reset bit drives reset signaling
// - Update writes token or handshake code
package usbc_pkg;
  // Register word indices
  localparam logic [3:0] REG_IRQ_FLAGS = 4'h0;
  localparam logic [3:0] REG_IRQ_EN = 4'h1;
  localparam logic [3:0] REG_ERR_FLAGS = 4'h2;
  localparam logic [3:0] REG_ERR_EN = 4'h3;
  localparam logic [3:0] REG_MAIN_CTL = 4'h4;
  localparam logic [3:0] REG_OTG_CTL = 4'h5;
  localparam logic [3:0] REG_EP0_CTL = 4'h6;
  localparam logic [3:0] REG_EP1_CTL = 4'h7;
  localparam logic [3:0] REG_TARGET_ADDR = 4'h8;
  localparam logic [3:0] REG_POWER = 4'h9;
  localparam logic [3:0] REG_DESC_BASE = 4'ha;
  localparam logic [3:0] REG_FRAME_CNT = 4'he;
  localparam int DESC_NUM = 4;
  // Descriptor status word fields
  localparam int DS_OWN = 15;
  localparam int DS_TGL = 14;
  localparam int DS_PID_LSB = 10;
  localparam int DS_TCE = 11;
  localparam int DS_STALL = 10;
  localparam int DS_BC_MSB = 9;
  // Status flag positions
  localparam int IRQ_ERR = 1;
  localparam int IRQ_SOF = 2;
  localparam int IRQ_TRN = 3;
  localparam int IRQ_ATTACH = 6;
  localparam int IRQ_STALL = 7;
  // Error flag positions
  localparam int ERR_TOGGLE = 0;
  localparam int ERR_CRC = 1;
  // Main control fields
  localparam int MC_EN = 0;
  localparam int MC_PPRST = 1;
  localparam int MC_HOST = 3;
  localparam int MC_BUSRST = 4;
  localparam int MC_INDICATOR_A = 7;
  // Endpoint control and address fields
  localparam int EP_HSHK = 0;
  localparam int EP_STALLIND = 1;
  localparam int EP_LOW_SPEED_ENDPOINT_BIT = 7;
  localparam int ADDR_LOW_SPEED_ENDPOINT_BIT = 7;
  // Packet identifiers
  localparam logic [3:0] PID_OUT = 4'h1;
  localparam logic [3:0] PID_ACK = 4'h2;
  localparam logic [3:0] PID_NAK = 4'ha;
  localparam logic [3:0] PID_STALL = 4'he;
  // Reset values and frame timing
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [13:0] FRAME_LOAD = 14'd12000;
endpackage

//--- hw/usbc_sie_ctl.sv
// Purpose: descriptor handling, flags and host/device mode control
// Assumes: one clock, link engine presents decoded tokens
// Notes: frame counter ticks once per clock
`timescale 1ns/1ps
module usbc_sie_ctl #(
  parameter logic [13:0] FRAME_LOAD = usbc_pkg::FRAME_LOAD
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [15:0] reg_rdata_o,
  input wire logic tok_valid_i,
  input wire logic [3:0] tok_pid_i,
  input wire logic tok_ep_i,
  input wire logic tok_in_i,
  input wire logic pkt_toggle_i,
  input wire logic [9:0] pkt_len_i,
  input wire logic pkt_err_i,
  input wire logic dp_i,
  input wire logic dm_i,
  output logic hs_valid_o,
  output logic [3:0] hs_pid_o,
  output logic tx_start_o,
  output logic [9:0] tx_len_o,
  output logic tx_toggle_o,
  output logic sof_o,
  output logic bus_rst_o,
  output logic dp_pu_o,
  output logic dm_pu_o,
  output logic dp_pd_o,
  output logic dm_pd_o,
  output logic irq_o
);
  import usbc_pkg::*;

  logic [7:0] irq_flags, irq_en, err_flags, err_en;
  logic [7:0] main_ctl, otg_ctl, addr_reg, pwr_reg;
  logic [7:0] ep_ctl [2];
  logic [15:0] desc [DESC_NUM];
  logic [13:0] frame_cnt;
  logic host_q, prev_se0;

  // Register select helper
  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    return a == r;
  endfunction

  logic host, dev_act, tok_fire;
  logic [1:0] idx;
  logic [15:0] d;
  logic own, stall, tce, tgl, tgl_bad, zlp_status;
  logic [9:0] bc_in, moved;
  logic stall_hit, drop_hit, err_hit, done_hit, nak_hit;
  logic [7:0] irq_set, err_set, irq_clr, err_clr;
  logic attach_set, sof_fire;

  // Token decode against the selected descriptor; reserved bits 13:12 are never looked at
  always_comb begin
    host = main_ctl[MC_HOST];
    dev_act = main_ctl[MC_EN] & pwr_reg[0] & ~host;
    tok_fire = tok_valid_i & (dev_act | host);
    idx = {tok_ep_i & ~host, tok_in_i};
    d = desc[idx];
    own = d[DS_OWN];
    stall = d[DS_STALL] & ~host;
    tce = d[DS_TCE];
    tgl = d[DS_TGL];
    bc_in = d[DS_BC_MSB:0];
    tgl_bad = tce & ~tok_in_i & (pkt_toggle_i != tgl);
    moved = tok_in_i ? bc_in : ((pkt_len_i < bc_in) ? pkt_len_i : bc_in);
    zlp_status = ~tok_in_i & ~tok_ep_i & (pkt_len_i == 10'h000) & ep_ctl[0][EP_HSHK];
    nak_hit = tok_fire & ~host & ~own;
    stall_hit = tok_fire & own & stall;
    drop_hit = tok_fire & own & ~stall & tgl_bad;
    err_hit = tok_fire & own & ~stall & ~tgl_bad & pkt_err_i;
    done_hit = tok_fire & own & ~stall & ~tgl_bad & ~pkt_err_i;
  end

  // Flag set and write-one-clear terms
  always_comb begin
    err_set = 8'h00;
    err_set[ERR_TOGGLE] = drop_hit;
    err_set[ERR_CRC] = err_hit;
    irq_set = 8'h00;
    irq_set[IRQ_ERR] = |err_set;
    irq_set[IRQ_SOF] = sof_fire;
    irq_set[IRQ_TRN] = done_hit;
    irq_set[IRQ_ATTACH] = attach_set;
    irq_set[IRQ_STALL] = stall_hit;
    irq_clr = (reg_we_i && hit(reg_addr_i, REG_IRQ_FLAGS)) ? reg_wdata_i[7:0] : 8'h00;
    err_clr = (reg_we_i && hit(reg_addr_i, REG_ERR_FLAGS)) ? reg_wdata_i[7:0] : 8'h00;
  end

  // Sticky flags, set wins over clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_flags <= RST_BYTE;
      err_flags <= RST_BYTE;
    end else begin
      irq_flags <= (irq_flags & ~irq_clr) | irq_set;
      err_flags <= (err_flags & ~err_clr) | err_set;
    end
  end

  // Control registers; host-only bits need host mode
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_en <= RST_BYTE;
      err_en <= RST_BYTE;
      main_ctl <= RST_BYTE;
      otg_ctl <= RST_BYTE;
      addr_reg <= RST_BYTE;
      pwr_reg <= RST_BYTE;
      ep_ctl[0] <= RST_BYTE;
      ep_ctl[1] <= RST_BYTE;
    end else begin
      if (reg_we_i && hit(reg_addr_i, REG_IRQ_EN)) irq_en <= reg_wdata_i[7:0];
      if (reg_we_i && hit(reg_addr_i, REG_ERR_EN)) err_en <= reg_wdata_i[7:0];
      if (reg_we_i && hit(reg_addr_i, REG_OTG_CTL)) otg_ctl <= reg_wdata_i[7:0];
      if (reg_we_i && hit(reg_addr_i, REG_POWER)) pwr_reg <= {7'h00, reg_wdata_i[0]};
      if (reg_we_i && hit(reg_addr_i, REG_MAIN_CTL)) begin
        main_ctl <= {1'b0, reg_wdata_i[6:5], reg_wdata_i[MC_BUSRST] & host,
                     reg_wdata_i[3:0]};
      end else if (host && !host_q) begin
        main_ctl[MC_EN] <= 1'b1;
      end
      if (reg_we_i && hit(reg_addr_i, REG_TARGET_ADDR)) begin
        addr_reg <= {reg_wdata_i[ADDR_LOW_SPEED_ENDPOINT_BIT] & host, reg_wdata_i[6:0]};
      end
      for (int e = 0; e < 2; e++) begin
        if (reg_we_i && hit(reg_addr_i, REG_EP0_CTL + 4'(e))) begin
          ep_ctl[e] <= {reg_wdata_i[EP_LOW_SPEED_ENDPOINT_BIT] & host, reg_wdata_i[6:0]};
        end
        // Hardware stall indication wins over a software write
        if (stall_hit && idx[1] == e[0]) begin
          ep_ctl[e][EP_STALLIND] <= 1'b1;
        end
      end
    end
  end

  // Descriptor words; the module's update beats a software write
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < DESC_NUM; i++) desc[i] <= RST_WORD;
    end else begin
      for (int i = 0; i < DESC_NUM; i++) begin
        if (done_hit && idx == i[1:0]) begin
          desc[i] <= {1'b0, tgl, tok_pid_i, host ? pkt_len_i : moved};
        end else if (reg_we_i && hit(reg_addr_i, REG_DESC_BASE + 4'(i))) begin
          desc[i] <= reg_wdata_i;
        end
      end
    end
  end

  // Device answers: handshake and transmit start
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hs_valid_o <= 1'b0;
      hs_pid_o <= 4'h0;
      tx_start_o <= 1'b0;
      tx_len_o <= 10'h000;
      tx_toggle_o <= 1'b0;
    end else begin
      hs_valid_o <= 1'b0;
      tx_start_o <= 1'b0;
      if (stall_hit) begin
        hs_valid_o <= 1'b1;
        hs_pid_o <= PID_STALL;
      end else if (nak_hit && !tok_in_i) begin
        hs_valid_o <= 1'b1;
        hs_pid_o <= zlp_status ? PID_ACK : PID_NAK;
      end else if (nak_hit) begin
        hs_valid_o <= 1'b1;
        hs_pid_o <= PID_NAK;
      end else if (done_hit && !host && !tok_in_i) begin
        hs_valid_o <= 1'b1;
        hs_pid_o <= PID_ACK;
      end else if (done_hit && !host) begin
        tx_start_o <= 1'b1;
        tx_len_o <= bc_in;
        tx_toggle_o <= tgl;
      end
    end
  end

  // Attach detect: SE0 followed by a driven line
  always_comb begin
    attach_set = host & prev_se0 & (dp_i | dm_i);
    sof_fire = host & main_ctl[MC_EN] & (frame_cnt == 14'd1);
  end

  // Frame counter and line state history
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      frame_cnt <= FRAME_LOAD;
      host_q <= 1'b0;
      prev_se0 <= 1'b0;
      sof_o <= 1'b0;
    end else begin
      host_q <= host;
      prev_se0 <= ~dp_i & ~dm_i;
      sof_o <= sof_fire;
      if (!host || !main_ctl[MC_EN] || sof_fire) frame_cnt <= FRAME_LOAD;
      else frame_cnt <= frame_cnt - 14'd1;
    end
  end

  // Pin controls and the shared interrupt request
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bus_rst_o <= 1'b0;
      dp_pu_o <= 1'b0;
      dm_pu_o <= 1'b0;
      dp_pd_o <= 1'b0;
      dm_pd_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      bus_rst_o <= host & main_ctl[MC_BUSRST];
      dp_pu_o <= otg_ctl[7];
      dm_pu_o <= otg_ctl[6];
      dp_pd_o <= otg_ctl[5];
      dm_pd_o <= otg_ctl[4];
      irq_o <= |(irq_flags & irq_en);
    end
  end

  // Read port, data valid in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= RST_WORD;
    end else if (!reg_re_i) begin
      reg_rdata_o <= RST_WORD;
    end else begin
      case (reg_addr_i)
        REG_IRQ_FLAGS: reg_rdata_o <= {8'h00, irq_flags};
        REG_IRQ_EN: reg_rdata_o <= {8'h00, irq_en};
        REG_ERR_FLAGS: reg_rdata_o <= {8'h00, err_flags};
        REG_ERR_EN: reg_rdata_o <= {8'h00, err_en};
        REG_MAIN_CTL: reg_rdata_o <= {8'h00, dp_i & ~dm_i, main_ctl[6:0]};
        REG_OTG_CTL: reg_rdata_o <= {8'h00, otg_ctl};
        REG_EP0_CTL: reg_rdata_o <= {8'h00, ep_ctl[0]};
        REG_EP1_CTL: reg_rdata_o <= {8'h00, ep_ctl[1]};
        REG_TARGET_ADDR: reg_rdata_o <= {8'h00, addr_reg};
        REG_POWER: reg_rdata_o <= {8'h00, pwr_reg};
        REG_FRAME_CNT: reg_rdata_o <= {2'h0, frame_cnt};
        default: begin
          if (reg_addr_i <= REG_DESC_BASE + 4'h3) reg_rdata_o <= desc[reg_addr_i[1:0] - 2'h2];
          else reg_rdata_o <= RST_WORD;
        end
      endcase
    end
  end

  // Checks: one clock domain, reset masks every property
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // Stalled tokens: handshake, indication, descriptor kept
  stall_answer_a: assert property (stall_hit |=>
    hs_valid_o && hs_pid_o == PID_STALL)
    else $error("stall token not answered with STALL");
  stall_mark_a: assert property (stall_hit |=>
    irq_flags[IRQ_STALL] && ep_ctl[$past(idx[1])][EP_STALLIND])
    else $error("stall indication missing");
  stall_keep_a: assert property (stall_hit && !reg_we_i |=>
    desc[$past(idx)] == $past(d))
    else $error("stalled descriptor changed");

  // Unowned descriptors: no data, no update, status phase acknowledged
  unowned_ignore_a: assert property (nak_hit |=>
    !tx_start_o && (!irq_flags[IRQ_TRN] || $past(irq_flags[IRQ_TRN])))
    else $error("unowned descriptor used");
  unowned_keep_a: assert property (nak_hit && !reg_we_i |=>
    desc[$past(idx)] == $past(d))
    else $error("unowned descriptor changed");
  status_ack_a: assert property (nak_hit && zlp_status |=>
    hs_valid_o && hs_pid_o == PID_ACK)
    else $error("status phase not acknowledged");

  // Owned descriptors: toggle check, completion, byte count, packet code
  toggle_drop_a: assert property (drop_hit |=>
    !hs_valid_o && err_flags[ERR_TOGGLE] && irq_flags[IRQ_ERR])
    else $error("toggle mismatch not dropped");
  toggle_free_a: assert property (tok_fire && own && !stall && !tce && !pkt_err_i |=>
    irq_flags[IRQ_TRN])
    else $error("toggle used while check is off");
  in_done_a: assert property (done_hit && !host && tok_in_i |=>
    tx_start_o && irq_flags[IRQ_TRN])
    else $error("IN transfer not completed");
  out_done_a: assert property (done_hit && !host && !tok_in_i |=>
    hs_pid_o == PID_ACK && !desc[$past(idx)][DS_OWN])
    else $error("OUT transfer not completed");
  count_moved_a: assert property (done_hit && !host |=>
    desc[$past(idx)][DS_BC_MSB:0] <= $past(bc_in))
    else $error("byte count beyond the buffer");
  pid_write_a: assert property (done_hit |=>
    desc[$past(idx)][DS_PID_LSB+3:DS_PID_LSB] == $past(tok_pid_i))
    else $error("packet code not written back");
  crc_error_a: assert property (err_hit |=>
    !hs_valid_o && err_flags[ERR_CRC] && irq_flags[IRQ_ERR])
    else $error("packet error not flagged");
  host_quiet_a: assert property (host && tok_fire |=>
    !hs_valid_o && !tx_start_o)
    else $error("handshake sent in host mode");
  host_ep0_a: assert property (host && tok_fire |-> !idx[1])
    else $error("host transfer off endpoint 0");

  // Interrupt flags and the shared request
  err_summary_a: assert property (|err_set |=> irq_flags[IRQ_ERR])
    else $error("error summary not set");
  flag_clear_a: assert property (irq_clr[IRQ_TRN] && !done_hit |=> !irq_flags[IRQ_TRN])
    else $error("write one did not clear");
  flag_keep_a: assert property (irq_flags[IRQ_TRN] && !irq_clr[IRQ_TRN] |=>
    irq_flags[IRQ_TRN])
    else $error("flag lost without a write of one");
  set_wins_a: assert property (irq_clr[IRQ_TRN] && done_hit |=> irq_flags[IRQ_TRN])
    else $error("set lost to clear");
  irq_out_a: assert property (|(irq_flags & irq_en) |=> irq_o)
    else $error("interrupt not raised");

  // Host mode: frame start, bus reset, gated bits, line state
  frame_tick_a: assert property (sof_o && host && main_ctl[MC_EN] |=>
    !sof_o && frame_cnt == FRAME_LOAD - 14'd1)
    else $error("frame counter not reloaded");
  frame_stop_a: assert property (!main_ctl[MC_EN] |=> !sof_o)
    else $error("frame start while disabled");
  bus_reset_a: assert property (host && main_ctl[MC_BUSRST] |=> bus_rst_o)
    else $error("bus reset not driven");
  addr_gate_a: assert property (reg_we_i && hit(reg_addr_i, REG_TARGET_ADDR) && !host |=>
    !addr_reg[ADDR_LOW_SPEED_ENDPOINT_BIT])
    else $error("host-only bit written outside host mode");
  attach_flag_a: assert property (attach_set |=> irq_flags[IRQ_ATTACH])
    else $error("attach not flagged");
  indicator_a_read_a: assert property (reg_re_i && reg_addr_i == REG_MAIN_CTL |=>
    reg_rdata_o[MC_INDICATOR_A] == ($past(dp_i) && !$past(dm_i)))
    else $error("J indicator misread");

  // Main scenarios
  in_cov_c: cover property (done_hit && tok_in_i ##1 tx_start_o);
  out_cov_c: cover property (done_hit && !host && !tok_in_i);
  stall_cov_c: cover property (stall_hit);
  sof_cov_c: cover property (sof_o);
  attach_cov_c: cover property (attach_set);
endmodule // usbc_sie_ctl

//--- dv/usbc_host_model.sv
// Purpose: far-side model giving decoded tokens and bus line levels
// Assumes: fields change just after a rising clock edge
// Notes: token fields are scrambled once the token has been taken
`timescale 1ns/1ps
module usbc_host_model (
  input wire logic clk_i,
  output logic tok_valid_o,
  output logic [3:0] tok_pid_o,
  output logic tok_ep_o,
  output logic tok_in_o,
  output logic pkt_toggle_o,
  output logic [9:0] pkt_len_o,
  output logic pkt_err_o,
  output logic dp_o,
  output logic dm_o
);
  // Idle bus at SE0, no token
  initial begin
    {tok_valid_o, tok_pid_o, tok_ep_o, tok_in_o, pkt_toggle_o, pkt_len_o, pkt_err_o, dp_o,
      dm_o} = 21'h0;
  end

  // One token for one cycle, then stale fields are inverted
  task automatic send(input logic [3:0] pid, input logic ep, input logic din,
      input logic tgl, input logic [9:0] len, input logic err);
    @(posedge clk_i);
    {tok_valid_o, tok_pid_o, tok_ep_o, tok_in_o, pkt_toggle_o, pkt_len_o, pkt_err_o} <=
      {1'b1, pid, ep, din, tgl, len, err};
    @(posedge clk_i);
    {tok_valid_o, tok_pid_o, tok_ep_o, tok_in_o, pkt_toggle_o, pkt_len_o, pkt_err_o} <=
      {1'b0, ~pid, ~ep, ~din, ~tgl, ~len, ~err};
  endtask

  // Bus line levels
  task automatic lines(input logic p, input logic m);
    @(posedge clk_i);
    dp_o <= p;
    dm_o <= m;
  endtask
endmodule // usbc_host_model

//--- dv/usbc_sie_ctl_tb.sv
// Purpose: self-checking bench for the descriptor and mode control block
// Assumes: read data stand in the cycle after the read strobe
// Notes: frame length shortened to FL clocks
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %h want %h", $time, a, e); end end
module usbc_sie_ctl_tb;
  import usbc_pkg::*;
  localparam logic [13:0] FL = 14'd20;
  logic clk_i, sys_rst_i, reg_we_i, reg_re_i, tok_valid_i, tok_ep_i, tok_in_i;
  logic pkt_toggle_i, pkt_err_i, dp_i, dm_i, hs_valid_o, tx_start_o, tx_toggle_o;
  logic sof_o, bus_rst_o, dp_pu_o, dm_pu_o, dp_pd_o, dm_pd_o, irq_o;
  logic [3:0] reg_addr_i, tok_pid_i, hs_pid_o;
  logic [15:0] reg_wdata_i, reg_rdata_o;
  logic [9:0] pkt_len_i, tx_len_o;
  int n_fail, n_compared;

  usbc_sie_ctl #(.FRAME_LOAD(FL)) i_usbc_sie_ctl (.clk_i, .sys_rst_i, .reg_addr_i,
    .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .tok_valid_i, .tok_pid_i, .tok_ep_i,
    .tok_in_i, .pkt_toggle_i, .pkt_len_i, .pkt_err_i, .dp_i, .dm_i, .hs_valid_o, .hs_pid_o,
    .tx_start_o, .tx_len_o, .tx_toggle_o, .sof_o, .bus_rst_o, .dp_pu_o, .dm_pu_o, .dp_pd_o,
    .dm_pd_o, .irq_o);

  usbc_host_model i_usbc_host_model (.clk_i, .tok_valid_o(tok_valid_i),
    .tok_pid_o(tok_pid_i), .tok_ep_o(tok_ep_i), .tok_in_o(tok_in_i),
    .pkt_toggle_o(pkt_toggle_i), .pkt_len_o(pkt_len_i), .pkt_err_o(pkt_err_i),
    .dp_o(dp_i), .dm_o(dm_i));

  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Verdict and end of run
  task automatic results;
    $display("comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Single-cycle register write
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask

  // Read; data taken in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  // Read and compare
  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask

  // Token, outputs judged 1 ns after the edge that takes it
  task automatic tok(input logic [3:0] p, input logic ep, input logic din, input logic t,
      input logic [9:0] n);
    i_usbc_host_model.send(p, ep, din, t, n, 1'b0);
    #1;
  endtask

  // Clocks between two frame-start pulses, bounded
  task automatic sof_gap(output int n);
    int k;
    int seen;
    seen = 0;
    n = 0;
    for (k = 0; k < 100 && seen < 2; k++) begin
      @(posedge clk_i);
      #1;
      if (seen == 1) n++;
      if (sof_o === 1'b1) seen++;
    end
    if (seen < 2) begin
      n_fail++;
      results();
    end
  endtask

  // Everything but the frame counter at index 14 reads zero after reset, unmapped index too
  task automatic t_reset;
    for (int i = 0; i < 16; i++) begin
      if (i != 14) rdc(4'(i), 16'h0000);
    end
  endtask

  // Device bring-up in the documented order
  task automatic t_bringup;
    wr(REG_MAIN_CTL, 16'h0002);
    wr(REG_MAIN_CTL, 16'h0000);
    wr(REG_IRQ_EN, 16'h0000);
    wr(REG_ERR_EN, 16'h0000);
    wr(REG_IRQ_FLAGS, 16'h00ff);
    wr(REG_ERR_FLAGS, 16'h00ff);
    wr(REG_MAIN_CTL, 16'h0001);
    wr(REG_OTG_CTL, 16'h0004);
    wr(REG_EP0_CTL, 16'h0009);
    wr(REG_EP1_CTL, 16'h0009);
    wr(REG_POWER, 16'h0001);
    wr(REG_OTG_CTL, 16'h0084);
    @(posedge clk_i);
    #1 `CHK({dp_pu_o, dp_pd_o}, 2'b10)
  endtask

  // IN on owned ep1 descriptor, full count, then flag clearing
  task automatic t_in;
    wr(REG_DESC_BASE + 4'h3, 16'h03ff);
    wr(REG_DESC_BASE + 4'h3, 16'h83ff);
    wr(REG_IRQ_EN, 16'h0008);
    tok(4'h9, 1'b1, 1'b1, 1'b0, 10'h000);
    `CHK({tx_start_o, tx_len_o, tx_toggle_o}, {1'b1, 10'h3ff, 1'b0})
    @(posedge clk_i);
    #1 `CHK(irq_o, 1'b1)
    rdc(REG_DESC_BASE + 4'h3, 16'h27ff);
    rdc(REG_IRQ_FLAGS, 16'h0008);
    wr(REG_IRQ_FLAGS, 16'h0000);
    rdc(REG_IRQ_FLAGS, 16'h0008);
    wr(REG_IRQ_FLAGS, 16'h0008);
    rdc(REG_IRQ_FLAGS, 16'h0000);
    `CHK(irq_o, 1'b0)
  endtask

  // OUT with toggle check: mismatch dropped, match stored
  task automatic t_out;
    wr(REG_DESC_BASE + 4'h2, 16'h4810);
    wr(REG_DESC_BASE + 4'h2, 16'hc810);
    tok(PID_OUT, 1'b1, 1'b0, 1'b0, 10'h005);
    `CHK(hs_valid_o, 1'b0)
    rdc(REG_ERR_FLAGS, 16'h0001);
    rdc(REG_IRQ_FLAGS, 16'h0002);
    tok(PID_OUT, 1'b1, 1'b0, 1'b1, 10'h005);
    `CHK({hs_valid_o, hs_pid_o}, {1'b1, PID_ACK})
    rdc(REG_DESC_BASE + 4'h2, 16'h4405);
    rdc(REG_IRQ_FLAGS, 16'h000a);
    wr(REG_ERR_FLAGS, 16'h00ff);
    wr(REG_IRQ_FLAGS, 16'h00ff);
    wr(REG_DESC_BASE + 4'h2, 16'h0010);
    wr(REG_DESC_BASE + 4'h2, 16'h8010);
    i_usbc_host_model.send(PID_OUT, 1'b1, 1'b0, 1'b0, 10'h005, 1'b1);
    #1 `CHK(hs_valid_o, 1'b0)
    rdc(REG_ERR_FLAGS, 16'h0002);
    rdc(REG_IRQ_FLAGS, 16'h0002);
    wr(REG_ERR_FLAGS, 16'h00ff);
    wr(REG_IRQ_FLAGS, 16'h00ff);
  endtask

  // Owned descriptor with stall bit, then unowned ones
  task automatic t_stall;
    logic [15:0] d;
    wr(REG_DESC_BASE, 16'h8408);
    tok(PID_OUT, 1'b0, 1'b0, 1'b0, 10'h004);
    `CHK({hs_valid_o, hs_pid_o}, {1'b1, PID_STALL})
    rdc(REG_DESC_BASE, 16'h8408);
    rd(REG_EP0_CTL, d);
    `CHK(d[EP_STALLIND], 1'b1)
    rdc(REG_IRQ_FLAGS, 16'h0080);
    wr(REG_IRQ_FLAGS, 16'h00ff);
    wr(REG_DESC_BASE, 16'h0000);
    tok(4'h9, 1'b1, 1'b1, 1'b0, 10'h000);
    `CHK({hs_valid_o, hs_pid_o, tx_start_o}, {1'b1, PID_NAK, 1'b0})
    rdc(REG_DESC_BASE + 4'h3, 16'h27ff);
    tok(PID_OUT, 1'b0, 1'b0, 1'b0, 10'h000);
    `CHK({hs_valid_o, hs_pid_o}, {1'b1, PID_ACK})
  endtask

  // Host mode: gating, frame start, attach, bus reset
  task automatic t_host;
    logic [15:0] d;
    int n;
    wr(REG_TARGET_ADDR, 16'h0080);
    wr(REG_MAIN_CTL, 16'h0011);
    rdc(REG_TARGET_ADDR, 16'h0000);
    `CHK(bus_rst_o, 1'b0)
    wr(REG_MAIN_CTL, 16'h0009);
    wr(REG_OTG_CTL, 16'h0030);
    wr(REG_TARGET_ADDR, 16'h0080);
    rdc(REG_TARGET_ADDR, 16'h0080);
    wr(REG_DESC_BASE, 16'h0040);
    wr(REG_DESC_BASE, 16'h8040);
    tok(PID_ACK, 1'b1, 1'b0, 1'b0, 10'h003);
    `CHK({hs_valid_o, tx_start_o}, 2'b00)
    rdc(REG_DESC_BASE, 16'h0803);
    `CHK({dp_pd_o, dm_pd_o, dp_pu_o}, 3'b110)
    sof_gap(n);
    `CHK(n, int'(FL))
    i_usbc_host_model.lines(1'b1, 1'b0);
    rd(REG_IRQ_FLAGS, d);
    `CHK(d[IRQ_ATTACH], 1'b1)
    rd(REG_MAIN_CTL, d);
    `CHK(d[MC_INDICATOR_A], 1'b1)
    repeat (FL) @(posedge clk_i);
    wr(REG_MAIN_CTL, 16'h0019);
    @(posedge clk_i);
    #1 `CHK(bus_rst_o, 1'b1)
    wr(REG_MAIN_CTL, 16'h0008);
    repeat (2) @(posedge clk_i);
    n = 0;
    repeat (3 * FL) begin
      @(posedge clk_i);
      #1;
      if (sof_o !== 1'b0) n++;
    end
    `CHK(n, 0)
    wr(REG_MAIN_CTL, 16'h0009);
    sof_gap(n);
    `CHK(n, int'(FL))
  endtask

  // Reset, then the scenarios in turn
  initial begin
    n_fail = 0;
    n_compared = 0;
    sys_rst_i = 1'b1;
    reg_we_i = 1'b0;
    reg_re_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 16'h0000;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_bringup();
    t_in();
    t_out();
    t_stall();
    t_host();
    results();
  end
endmodule // usbc_sie_ctl_tb
